// [syp_port.sv]
// syp_port: synchronous serial port, spi side with i2c register basics
// assumes: wishbone classic master on clk_sys; pins arrive unsynchronised
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
module syp_port import syp_pkg::*; #(
    parameter int ADDR_W = 5
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    input wire logic slave_select_n,
    input wire logic timer2_tick,
    input wire logic power_sleep,
    input wire logic power_idle,
    output logic port_irq_flag,
    output logic wake_request,
    output logic slew_control_on,
    output logic smbus_inputs_on,
    output logic i2c_ten_bit,
    output logic [7:0] i2c_own_address,
    output logic [6:0] i2c_baud_reload
);
    // ==========================================================
    // functions
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] off);
        hit = (a == ADDR_W'(off));
    endfunction

    function automatic logic [5:0] half_of(input logic [3:0] m);
        case (m)
            MODE_M_DIV4: half_of = HALF_DIV4;
            MODE_M_DIV16: half_of = HALF_DIV16;
            default: half_of = HALF_DIV64;
        endcase
    endfunction

    // ==========================================================
    // pin synchronisers: sck, data in, select
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic sck_s3;
    logic sdi_s3;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1 <= 3'h7;
            pin_s2 <= 3'h7;
            sck_s3 <= 1'b1;
            sdi_s3 <= 1'b1;
        end else begin
            pin_s1 <= {slave_select_n, serial_in_pin, sck_in};
            pin_s2 <= pin_s1;
            sck_s3 <= pin_s2[0];
            sdi_s3 <= pin_s2[1];
        end
    end

    wire sck_sync = pin_s2[0];
    wire sdi_sync = pin_s2[1];
    wire ss_sync = pin_s2[2];

    // ==========================================================
    // registers
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic [7:0] buf_reg;
    logic [7:0] addr_reg;
    logic [2:0] aux;
    logic [7:0] shift_register;
    logic [2:0] bit_cnt;
    logic hold_bit;
    logic out_bit;
    logic m_active;
    logic [5:0] div_cnt;
    syp_state_t state;

    // ==========================================================
    // decode
    wire bus_req = wb_cyc_i & wb_stb_i & wb_ack_o;
    wire wr_en = bus_req & wb_we_i & wb_sel_i[0];
    wire rd_en = bus_req & !wb_we_i;
    wire wr_buf = wr_en & hit(wb_adr_i, OFF_BUF);
    wire wr_ctrl = wr_en & hit(wb_adr_i, OFF_CTRL);
    wire wr_stat = wr_en & hit(wb_adr_i, OFF_STAT);
    wire wr_addr = wr_en & hit(wb_adr_i, OFF_ADDR);
    wire wr_aux = wr_en & hit(wb_adr_i, OFF_AUX);
    wire rd_buf = rd_en & hit(wb_adr_i, OFF_BUF);

    wire [3:0] mode = ctrl[3:0];
    wire en = ctrl[CTRL_EN];
    wire clock_idle_polarity = ctrl[CTRL_CKP];
    wire sample_phase = stat[STAT_SMP];
    wire cke = stat[STAT_CKE];
    wire is_master = en & (mode[3:2] == 2'b00);
    wire is_slave = en & ((mode == MODE_S_SEL) | (mode == MODE_S_NOSEL));
    wire sel_ctrl = (mode == MODE_S_SEL);
    wire is_i2c = en & !is_master & !is_slave;
    wire i2c_master = is_i2c & ((mode == MODE_I2C_M) | (mode == MODE_I2C_FW));
    wire i2c_irq_mode = is_i2c & ((mode == MODE_I2C_S7I) | (mode == MODE_I2C_S10I));
    wire port_rst = !en | (sel_ctrl & ss_sync);
    wire master_run = (state == SYP_RUN);

    // slave edges come only from the external clock, never gated by sleep
    wire sck_rise = sck_sync & !sck_s3;
    wire sck_fall = !sck_sync & sck_s3;
    wire s_lead = is_slave & !port_rst & (clock_idle_polarity ? sck_fall : sck_rise);
    wire s_trail = is_slave & !port_rst & (clock_idle_polarity ? sck_rise : sck_fall);

    // master divider halts in sleep
    wire div_end = (div_cnt == half_of(mode) - 6'h01);
    wire m_tick = is_master & master_run & !power_sleep & ((mode == MODE_M_TMR2) ? timer2_tick : div_end);
    wire m_lead = m_tick & !m_active;
    wire m_trail = m_tick & m_active;

    wire lead = s_lead | m_lead;
    wire trail = s_trail | m_trail;
    wire done = trail & (bit_cnt == BIT_LAST);
    wire [7:0] next_sr = {shift_register[6:0], cke ? hold_bit : sdi_sync};
    wire busy = master_run | (is_slave & (bit_cnt != 3'h0));
    wire load = wr_buf & !busy;
    wire collide = wr_buf & busy;
    wire overflow = done & stat[STAT_BF];

    wire i2c_start = is_i2c & sck_sync & sck_s3 & sdi_s3 & !sdi_sync;
    wire i2c_stop = is_i2c & sck_sync & sck_s3 & !sdi_s3 & sdi_sync;
    wire set_flag = done | (i2c_irq_mode & (i2c_start | i2c_stop));
    wire drive_sdo = is_slave ? (!sel_ctrl | !ss_sync) : is_master;
    wire next_oe = en & drive_sdo & !aux[AUX_SDO_IN];
    wire [7:0] stat_rd = {stat[7:6], 1'b0, stat[STAT_STOP], stat[STAT_START], 2'b00, stat[STAT_BF]};

    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (hit(wb_adr_i, OFF_BUF)) begin
            rd_byte = buf_reg;
        end else if (hit(wb_adr_i, OFF_CTRL)) begin
            rd_byte = ctrl;
        end else if (hit(wb_adr_i, OFF_STAT)) begin
            rd_byte = stat_rd;
        end else if (hit(wb_adr_i, OFF_ADDR)) begin
            rd_byte = addr_reg;
        end else if (hit(wb_adr_i, OFF_AUX)) begin
            rd_byte = {5'h00, aux};
        end
    end

    // ==========================================================
    // bus slave: ack one cycle after the request, unmapped reads as zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & !wb_ack_o;
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // ==========================================================
    // control, status and aux registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= RST_CTRL;
            stat <= RST_STAT;
            addr_reg <= RST_BYTE;
            aux <= RST_AUX;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wb_dat_i[7:0];
            end
            ctrl[CTRL_WCOL] <= collide | (wr_ctrl ? wb_dat_i[CTRL_WCOL] : ctrl[CTRL_WCOL]);
            ctrl[CTRL_OVFL] <= overflow | (wr_ctrl ? wb_dat_i[CTRL_OVFL] : ctrl[CTRL_OVFL]);
            if (wr_stat) begin
                stat[7:6] <= wb_dat_i[7:6];
            end
            if (!en) begin
                stat[STAT_STOP] <= 1'b0;
                stat[STAT_START] <= 1'b0;
            end else if (i2c_start | i2c_stop) begin
                stat[STAT_START] <= i2c_start;
                stat[STAT_STOP] <= i2c_stop;
            end
            stat[STAT_BF] <= (done & !stat[STAT_BF]) | (stat[STAT_BF] & !rd_buf) | overflow;
            if (wr_addr) begin
                addr_reg <= wb_dat_i[7:0];
            end
            if (wr_aux) begin
                aux[AUX_IRQ_EN] <= wb_dat_i[AUX_IRQ_EN];
                aux[AUX_SDO_IN] <= wb_dat_i[AUX_SDO_IN];
            end
            aux[AUX_FLAG] <= set_flag | (wr_aux ? wb_dat_i[AUX_FLAG] : aux[AUX_FLAG]);
        end
    end

    // ==========================================================
    // buffer: receive double buffered, write loads buffer and shifter
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            buf_reg <= RST_BYTE;
        end else if (done & !stat[STAT_BF]) begin
            buf_reg <= next_sr;
        end else if (load) begin
            buf_reg <= wb_dat_i[7:0];
        end
    end

    // ==========================================================
    // shifter, msb first
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shift_register <= RST_BYTE;
            bit_cnt <= 3'h0;
            hold_bit <= 1'b0;
            out_bit <= 1'b0;
        end else if (load) begin
            shift_register <= wb_dat_i[7:0];
            out_bit <= wb_dat_i[7];
            bit_cnt <= 3'h0;
        end else if (port_rst) begin
            bit_cnt <= 3'h0;
        end else if (lead) begin
            hold_bit <= sdi_sync;
            out_bit <= cke ? out_bit : shift_register[7];
        end else if (trail) begin
            shift_register <= next_sr;
            out_bit <= cke ? shift_register[6] : out_bit;
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    // ==========================================================
    // master clock generator
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= SYP_IDLE;
            div_cnt <= 6'h00;
            m_active <= 1'b0;
        end else begin
            case (state)
                SYP_IDLE: begin
                    div_cnt <= 6'h00;
                    m_active <= 1'b0;
                    if (load & is_master) begin
                        state <= SYP_RUN;
                    end
                end
                SYP_RUN: begin
                    if (!is_master | done) begin
                        state <= SYP_IDLE;
                        m_active <= 1'b0;
                    end else if (!power_sleep) begin
                        div_cnt <= div_end ? 6'h00 : div_cnt + 6'h01;
                        m_active <= m_tick ? !m_active : m_active;
                    end
                end
                default: state <= SYP_IDLE;
            endcase
        end
    end

    // ==========================================================
    // pin and side outputs
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
            serial_out_pin <= 1'b0;
            serial_out_oe <= 1'b0;
            port_irq_flag <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            sck_out <= clock_idle_polarity ^ m_active;
            sck_oe <= is_master;
            serial_out_pin <= out_bit;
            serial_out_oe <= next_oe;
            port_irq_flag <= aux[AUX_FLAG];
            wake_request <= aux[AUX_FLAG] & aux[AUX_IRQ_EN] & (power_sleep | power_idle);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            slew_control_on <= 1'b0;
            smbus_inputs_on <= 1'b0;
            i2c_ten_bit <= 1'b0;
            i2c_own_address <= RST_BYTE;
            i2c_baud_reload <= 7'h00;
        end else begin
            slew_control_on <= is_i2c & !sample_phase;
            smbus_inputs_on <= is_i2c & cke;
            i2c_ten_bit <= is_i2c & !i2c_master & mode[0];
            i2c_own_address <= (is_i2c & !i2c_master) ? addr_reg : RST_BYTE;
            i2c_baud_reload <= i2c_master ? addr_reg[6:0] : 7'h00;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence s_byte_end;
        done ##1 1'b1;
    endsequence

    a_select_release: assert property (en & sel_ctrl & ss_sync |=> !serial_out_oe)
        else $error("data output driven while select high");
    a_select_drive: assert property (en & sel_ctrl & !ss_sync & !aux[AUX_SDO_IN] |=> serial_out_oe)
        else $error("data output not driven while selected");
    a_count_reset: assert property (port_rst |=> bit_cnt == 3'h0)
        else $error("bit counter not cleared by port reset");
    a_rx_move: assert property (done & !stat[STAT_BF] |-> s_byte_end ##0 (buf_reg == $past(next_sr)) && stat[STAT_BF])
        else $error("received byte not moved to buffer");
    a_flag_set: assert property (done |=> aux[AUX_FLAG] ##1 port_irq_flag)
        else $error("flag not raised after full byte");
    a_sleep_freeze: assert property (power_sleep & master_run & is_master |=> $stable(bit_cnt) && $stable(m_active))
        else $error("master transfer advanced during sleep");
    a_wake_gate: assert property (!aux[AUX_IRQ_EN] |=> !wake_request)
        else $error("wake without interrupt enable");
    a_tx_load: assert property (load |=> shift_register == $past(wb_dat_i[7:0]) && buf_reg == shift_register)
        else $error("buffer write did not load both");
    a_sdo_input: assert property (aux[AUX_SDO_IN] |=> !serial_out_oe)
        else $error("transmit while output set as input");
    a_idle_level: assert property (!master_run ##1 !master_run |-> sck_out == $past(clock_idle_polarity))
        else $error("serial clock idle level wrong");
    a_done_wake: assert property (done & aux[AUX_IRQ_EN] ##1 aux[AUX_IRQ_EN] & (power_sleep | power_idle) |=> wake_request)
        else $error("completed byte did not wake with interrupt enabled");
    a_baud_reload: assert property (i2c_master |=> i2c_baud_reload == $past(addr_reg[6:0]))
        else $error("baud reload not taken from address register");
    a_select_hold: assert property (en & sel_ctrl & ss_sync |-> !lead && !trail)
        else $error("shifting while select held high");
endmodule

// [syp_pkg.sv]
// syp_pkg: register map, field positions, mode codes and timing counts
// assumes: shared by the serial port design and its bench
package syp_pkg;
    // ==========================================================
    // register map (byte addresses, one word each)
    localparam logic [4:0] OFF_BUF = 5'h00;
    localparam logic [4:0] OFF_CTRL = 5'h04;
    localparam logic [4:0] OFF_STAT = 5'h08;
    localparam logic [4:0] OFF_ADDR = 5'h0c;
    localparam logic [4:0] OFF_AUX = 5'h10;
    // ==========================================================
    // control one fields
    localparam int CTRL_WCOL = 7;
    localparam int CTRL_OVFL = 6;
    localparam int CTRL_EN = 5;
    localparam int CTRL_CKP = 4;
    // status fields
    localparam int STAT_SMP = 7;
    localparam int STAT_CKE = 6;
    localparam int STAT_STOP = 4;
    localparam int STAT_START = 3;
    localparam int STAT_BF = 0;
    // aux fields
    localparam int AUX_FLAG = 0;
    localparam int AUX_IRQ_EN = 1;
    localparam int AUX_SDO_IN = 2;
    // ==========================================================
    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_STAT = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_AUX = 3'h0;
    // ==========================================================
    // mode select codes
    localparam logic [3:0] MODE_M_DIV4 = 4'h0;
    localparam logic [3:0] MODE_M_DIV16 = 4'h1;
    localparam logic [3:0] MODE_M_DIV64 = 4'h2;
    localparam logic [3:0] MODE_M_TMR2 = 4'h3;
    localparam logic [3:0] MODE_S_SEL = 4'h4;
    localparam logic [3:0] MODE_S_NOSEL = 4'h5;
    localparam logic [3:0] MODE_I2C_S7 = 4'h6;
    localparam logic [3:0] MODE_I2C_S10 = 4'h7;
    localparam logic [3:0] MODE_I2C_M = 4'h8;
    localparam logic [3:0] MODE_I2C_FW = 4'hb;
    localparam logic [3:0] MODE_I2C_S7I = 4'he;
    localparam logic [3:0] MODE_I2C_S10I = 4'hf;
    // ==========================================================
    // serial clock half periods in system clocks (fosc/4, /16, /64)
    localparam logic [5:0] HALF_DIV4 = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    localparam logic [2:0] BIT_LAST = 3'h7;
    typedef enum logic [0:0] {
        SYP_IDLE,
        SYP_RUN
    } syp_state_t;
endpackage

// [syp_spi_master_model.sv]
// syp_spi_master_model: spi master and i2c line driver facing the port pins
// assumes: tasks are called right after a rising clk_sys edge
`timescale 1ns/1ns
module syp_spi_master_model (
    input wire logic clk_sys,
    input wire logic miso,
    input wire logic miso_oe,
    output logic sck,
    output logic ss_n,
    output logic mosi
);
    // ==========================================================
    // frame tasks
    localparam int HALF = 10;
    initial begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b1;
    end
    task automatic park(input logic clock_idle_polarity);
        sck <= clock_idle_polarity;
        @(posedge clk_sys);
    endtask
    task automatic xfer(input logic [7:0] tx, input int nbits, input logic clock_idle_polarity, input logic cke,
                        output logic [7:0] rx, output logic oe_seen);
        rx = 8'h00;
        oe_seen = 1'b0;
        ss_n <= 1'b0;
        mosi <= tx[7];
        repeat (HALF) @(posedge clk_sys);
        for (int i = 0; i < nbits; i++) begin
            if (!cke) begin
                mosi <= tx[7-i];
            end
            sck <= ~clock_idle_polarity;
            repeat (HALF) @(posedge clk_sys);
            rx = {rx[6:0], miso};
            oe_seen = oe_seen | miso_oe;
            sck <= clock_idle_polarity;
            if (cke && i < 7) begin
                mosi <= tx[6-i];
            end
            repeat (HALF) @(posedge clk_sys);
        end
        ss_n <= 1'b1;
        mosi <= ~mosi;
    endtask
    task automatic start_stop();
        sck <= 1'b1;
        mosi <= 1'b1;
        repeat (HALF) @(posedge clk_sys);
        mosi <= 1'b0;
        repeat (HALF) @(posedge clk_sys);
        mosi <= 1'b1;
        repeat (HALF) @(posedge clk_sys);
    endtask
endmodule

// [tb_top.sv]
// tb_top: self-checking bench for the serial port
// assumes: syp_port with wishbone classic, spi master model on the pins
`timescale 1ns/1ns
module tb_top import syp_pkg::*; ();
    // ==========================================================
    // signals
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [4:0] wb_adr_i = 5'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic power_sleep = 1'b0;
    logic power_idle = 1'b0;
    logic loop = 1'b0;
    logic t2_tick = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, sck_out, sck_oe, serial_out_pin, serial_out_oe, port_irq_flag, wake_request;
    logic slew_control_on, smbus_inputs_on, i2c_ten_bit, p_sck, p_ss_n, p_mosi, din_mux;
    logic [7:0] i2c_own_address;
    logic [6:0] i2c_baud_reload;
    logic [7:0] tx, mo, rx;
    logic [15:0] e;
    logic oe, clock_idle_polarity, cke, s, frozen;
    logic [3:0] im [3] = '{MODE_I2C_M, MODE_I2C_S7, MODE_I2C_S10};
    logic [15:0] q [$];
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    int unsigned seed_r;
    assign din_mux = loop ? serial_out_pin : p_mosi;
    always #5 clk_sys = ~clk_sys;
    syp_port i_syp_port (.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .sck_in(p_sck), .sck_out, .sck_oe, .serial_in_pin(din_mux),
        .serial_out_pin, .serial_out_oe, .slave_select_n(p_ss_n), .timer2_tick(t2_tick), .power_sleep,
        .power_idle, .port_irq_flag, .wake_request, .slew_control_on, .smbus_inputs_on, .i2c_ten_bit,
        .i2c_own_address, .i2c_baud_reload);
    syp_spi_master_model i_model (.clk_sys, .miso(serial_out_pin), .miso_oe(serial_out_oe),
        .sck(p_sck), .ss_n(p_ss_n), .mosi(p_mosi));
    // ==========================================================
    // tasks
    task automatic conclude();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        tests_run++;
        if (g !== x) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d, input logic [7:0] m);
        int n;
        n = 0;
        if (!we) begin
            q.push_back({d & m, m});
        end
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 8'h00);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] x);
        bus(1'b0, a, x, 8'hff);
    endtask
    task automatic slave_byte(input int nb);
        tx = 8'($urandom);
        mo = 8'($urandom);
        wr(OFF_BUF, tx);
        i_model.xfer(mo, nb, clock_idle_polarity, cke, rx, oe);
        for (int n = 0; n < 40 && port_irq_flag !== 1'b1; n++) @(posedge clk_sys);
        repeat (3) @(posedge clk_sys);
    endtask
    // ==========================================================
    // read watcher and timeout
    always @(posedge clk_sys) begin
        cycles++;
        t2_tick <= (cycles % 8 == 0);
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q.size() > 0) begin
            e = q.pop_front();
            chk(wb_dat_o[7:0] & e[7:0], e[15:8]);
            chk(8'(|wb_dat_o[31:8]), 8'h00);
        end
        if (cycles == 40000) begin
            n_mismatch++;
            $display("CHECK FAILED %0t timeout", $time);
            conclude();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        seed_r = $urandom(32'h3fd3);
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd(OFF_CTRL, RST_CTRL);
        rd(OFF_STAT, RST_STAT);
        rd(OFF_AUX, {5'h00, RST_AUX});
        rd(5'h14, 8'h00);
        wr(OFF_STAT, 8'hff);
        rd(OFF_STAT, 8'hc0);
        wr(OFF_CTRL, 8'h1b);
        rd(OFF_CTRL, 8'h1b);
        for (int m = 0; m < 4; m++) begin
            clock_idle_polarity = m[1];
            cke = ~m[0];
            power_sleep <= m[0];
            i_model.park(clock_idle_polarity);
            wr(OFF_CTRL, 8'h00);
            wr(OFF_STAT, {1'b0, cke, 6'h00});
            wr(OFF_CTRL, {3'b001, clock_idle_polarity, MODE_S_SEL});
            wr(OFF_AUX, 8'h02);
            slave_byte(8);
            chk(rx, tx);
            chk({7'h0, port_irq_flag}, 8'h01);
            chk({7'h0, wake_request}, {7'h0, m[0]});
            rd(OFF_BUF, mo);
        end
        power_sleep <= 1'b0;
        clock_idle_polarity = 1'b0;
        cke = 1'b1;
        i_model.park(1'b0);
        wr(OFF_CTRL, 8'h00);
        wr(OFF_STAT, 8'h40);
        wr(OFF_CTRL, {3'b001, 1'b0, MODE_S_SEL});
        wr(OFF_AUX, 8'h02);
        slave_byte(4);
        chk({7'h0, serial_out_oe}, 8'h00);
        chk({7'h0, port_irq_flag}, 8'h00);
        slave_byte(8);
        chk(rx, tx);
        rd(OFF_BUF, mo);
        wr(OFF_AUX, 8'h06);
        slave_byte(8);
        chk({7'h0, oe}, 8'h00);
        rd(OFF_BUF, mo);
        wr(OFF_AUX, 8'h00);
        wr(OFF_CTRL, {3'b001, 1'b0, MODE_M_DIV16});
        loop <= 1'b1;
        power_idle <= 1'b1;
        tx = 8'($urandom);
        wr(OFF_BUF, tx);
        repeat (20) @(posedge clk_sys);
        power_sleep <= 1'b1;
        repeat (3) @(posedge clk_sys);
        s = sck_out;
        frozen = 1'b1;
        repeat (40) begin
            @(posedge clk_sys);
            if (sck_out !== s) frozen = 1'b0;
        end
        chk({7'h0, frozen}, 8'h01);
        power_sleep <= 1'b0;
        for (int n = 0; n < 1000 && port_irq_flag !== 1'b1; n++) @(posedge clk_sys);
        repeat (3) @(posedge clk_sys);
        chk({7'h0, port_irq_flag}, 8'h01);
        chk({7'h0, wake_request}, 8'h00);
        chk({7'h0, sck_out}, 8'h00);
        rd(OFF_BUF, tx);
        loop <= 1'b0;
        power_idle <= 1'b0;
        wr(OFF_AUX, 8'h00);
        wr(OFF_CTRL, {3'b001, 1'b0, MODE_M_TMR2});
        wr(OFF_BUF, 8'($urandom));
        for (int n = 0; n < 1000 && port_irq_flag !== 1'b1; n++) @(posedge clk_sys);
        chk({7'h0, port_irq_flag}, 8'h01);
        rd(OFF_BUF, {8{p_mosi}});
        wr(OFF_ADDR, 8'ha5);
        for (int k = 0; k < 3; k++) begin
            wr(OFF_CTRL, {4'h3, im[k]});
            repeat (2) @(posedge clk_sys);
            chk({1'b0, i2c_baud_reload}, k == 0 ? 8'h25 : 8'h00);
            chk(i2c_own_address, k == 0 ? 8'h00 : 8'ha5);
            chk({7'h0, i2c_ten_bit}, {7'h0, k == 2});
        end
        wr(OFF_STAT, 8'h80);
        repeat (2) @(posedge clk_sys);
        chk({6'h0, slew_control_on, smbus_inputs_on}, 8'h00);
        wr(OFF_STAT, 8'h40);
        repeat (2) @(posedge clk_sys);
        chk({6'h0, slew_control_on, smbus_inputs_on}, 8'h03);
        wr(OFF_CTRL, {4'h3, MODE_I2C_S7I});
        wr(OFF_AUX, 8'h00);
        i_model.start_stop();
        repeat (4) @(posedge clk_sys);
        chk({7'h0, port_irq_flag}, 8'h01);
        bus(1'b0, OFF_STAT, 8'h10, 8'h10);
        wr(OFF_CTRL, 8'h24);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd(OFF_CTRL, 8'h00);
        chk({7'h0, serial_out_oe}, 8'h00);
        conclude();
    end
endmodule
